// >>> core/aioc_host.sv
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module aioc_host (
  input wire logic clock_i,
  input wire logic rst_b_i,
  aioc_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SETUP = 3'b001,
    PH_ACTIVE = 3'b010,
    PH_HOLD = 3'b011,
    PH_WAIT = 3'b100
  } aioc_ph_e;

  aioc_ph_e ph_r;
  aioc_pkg::aioc_op_e op_r;
  logic [7:0] cnt_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic trig_mode_r;
  logic [7:0] data_r;
  logic [7:0] result_r;
  logic cs_n_r;
  logic wr_n_r;
  logic rd_n_r;
  logic st_n_r;
  logic rst_n_r;
  logic pick_r;
  logic oe_r;
  logic seen_busy_r;

  // AHB-Lite decode; zero wait states, always OKAY
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_cmd = wr_pend_r && (addr_r == aioc_pkg::CMD_OFS);
  wire wr_cfg = wr_pend_r && (addr_r == aioc_pkg::CFG_OFS);
  wire [2:0] cmd_op = hwdata[aioc_pkg::CMD_OP_LSB +: 3];
  // Conversion ops are refused while the converter is busy
  wire dev_busy = !link.busy_n;
  wire take = wr_cmd && (ph_r == PH_IDLE) && !(dev_busy && cmd_op != 3'(aioc_pkg::OP_WR_PRI)
              && cmd_op != 3'(aioc_pkg::OP_WR_SEC));
  wire cnt_done = (cnt_r == 8'h00);
  wire is_write = (op_r == aioc_pkg::OP_WR_PRI) || (op_r == aioc_pkg::OP_WR_SEC);
  wire [7:0] act_len = (op_r == aioc_pkg::OP_TRIG) ? 8'(aioc_pkg::TRIG_CYC)
                                                 : 8'(aioc_pkg::STROBE_CYC);

  // Bus slave registers
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      trig_mode_r <= aioc_pkg::CFG_RESET[aioc_pkg::CFG_TRIG];
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) addr_r <= haddr[7:0];
      if (wr_cfg && ph_r == PH_IDLE) trig_mode_r <= hwdata[aioc_pkg::CFG_TRIG];
    end
  end

  // Read mux, registered at the address phase
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i) hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        aioc_pkg::STAT_OFS: hrdata <= {29'h0, link.done_flag_n, link.busy_n, ph_r != PH_IDLE};
        aioc_pkg::RESULT_OFS: hrdata <= {24'h00_0000, result_r};
        aioc_pkg::CFG_OFS: hrdata <= {31'h0, trig_mode_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pin sequencer: setup, active strobe or busy wait, hold
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      ph_r <= PH_IDLE;
      op_r <= aioc_pkg::OP_NONE;
      cnt_r <= 8'h00;
      data_r <= 8'h00;
      result_r <= 8'h00;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      st_n_r <= 1'b1;
      rst_n_r <= 1'b1;
      pick_r <= 1'b0;
      oe_r <= 1'b0;
      seen_busy_r <= 1'b0;
    end
    else
    begin
      if (ph_r == PH_IDLE) st_n_r <= !trig_mode_r;
      if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      unique case (ph_r)
        PH_IDLE:
        begin
          if (take)
          begin
            op_r <= aioc_pkg::aioc_op_e'(cmd_op);
            data_r <= hwdata[aioc_pkg::CMD_DATA_LSB +: 8];
            pick_r <= (cmd_op == 3'(aioc_pkg::OP_WR_SEC));
            cnt_r <= 8'(aioc_pkg::STROBE_CYC);
            ph_r <= PH_SETUP;
          end
        end
        PH_SETUP:
        begin
          cs_n_r <= !(is_write || op_r == aioc_pkg::OP_READ || op_r == aioc_pkg::OP_STRB_CONV);
          oe_r <= is_write;
          if (cnt_done)
          begin
            wr_n_r <= !is_write;
            rd_n_r <= !(op_r == aioc_pkg::OP_READ || op_r == aioc_pkg::OP_STRB_CONV);
            rst_n_r <= !(op_r == aioc_pkg::OP_RESET);
            st_n_r <= (op_r == aioc_pkg::OP_TRIG) ? 1'b1 : st_n_r;
            cnt_r <= act_len;
            seen_busy_r <= 1'b0;
            ph_r <= (op_r == aioc_pkg::OP_STRB_CONV) ? PH_WAIT : PH_ACTIVE;
          end
        end
        PH_ACTIVE:
        begin
          if (cnt_done)
          begin
            if (op_r == aioc_pkg::OP_READ) result_r <= link.data_bus;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            rst_n_r <= 1'b1;
            st_n_r <= (op_r == aioc_pkg::OP_TRIG) ? 1'b0 : st_n_r;
            cnt_r <= 8'(aioc_pkg::STROBE_CYC);
            ph_r <= PH_HOLD;
          end
        end
        PH_WAIT:
        begin
          // Held here, bus not stalled, until busy was seen or the count ran out, and busy is high
          if (dev_busy) seen_busy_r <= 1'b1;
          if ((seen_busy_r || cnt_done) && link.busy_n)
          begin
            result_r <= link.data_bus;
            rd_n_r <= 1'b1;
            cnt_r <= 8'(aioc_pkg::STROBE_CYC);
            ph_r <= PH_HOLD;
          end
        end
        PH_HOLD:
        begin
          if (cnt_done)
          begin
            cs_n_r <= 1'b1;
            oe_r <= 1'b0;
            ph_r <= PH_IDLE;
          end
        end
        default: ph_r <= PH_IDLE;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign link.chip_select_n = cs_n_r;
  assign link.store_strobe_n = wr_n_r;
  assign link.read_strobe_n = rd_n_r;
  assign link.convert_trigger_n = st_n_r;
  assign link.reset_n = rst_n_r;
  assign link.channel_pick = pick_r;
  assign link.host_data = data_r;
  assign link.host_data_oe = oe_r;
endmodule : aioc_host

// >>> core/aioc_pkg.sv
package aioc_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CONV_CLK_NS = 250;
  localparam int CONV_HALF_CYC = (CONV_CLK_NS * CLK_MHZ) / 2000;
  localparam int CONV_BITS = 8;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIG_NS = 200;
  localparam int TRIG_CYC = (TRIG_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_SEEN_CYC = 4;

  // Host register map, byte addresses
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] CFG_OFS = 8'h0C;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  // Status register fields
  localparam int STAT_BUSY_OP = 0;
  localparam int STAT_BUSY_PIN = 1;
  localparam int STAT_DONE_PIN = 2;
  // Config register field: trigger mode when set
  localparam int CFG_TRIG = 0;

  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_WR_PRI = 3'b001,
    OP_WR_SEC = 3'b010,
    OP_TRIG = 3'b011,
    OP_READ = 3'b100,
    OP_STRB_CONV = 3'b101,
    OP_RESET = 3'b110
  } aioc_op_e;
endpackage : aioc_pkg

// >>> core/aioc_if.sv
`timescale 1ns/1ps
interface aioc_if;
  logic chip_select_n;
  logic store_strobe_n;
  logic read_strobe_n;
  logic channel_pick;
  logic convert_trigger_n;
  logic reset_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic busy_n;
  logic done_flag_n;
  logic conv_clk;
  logic [7:0] data_bus;

  // Shared data wire; undriven bus reads as pulled high
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);

  modport dev (
    input chip_select_n, store_strobe_n, read_strobe_n, channel_pick,
    input convert_trigger_n, reset_n, data_bus,
    output dev_data, dev_data_oe, busy_n, done_flag_n, conv_clk
  );
  modport host (
    output chip_select_n, store_strobe_n, read_strobe_n, channel_pick,
    output convert_trigger_n, reset_n, host_data, host_data_oe,
    input data_bus, busy_n, done_flag_n, conv_clk
  );
endinterface : aioc_if

// >>> core/aioc_dev.sv
`timescale 1ns/1ps
module aioc_dev (
  input wire logic clock_i,
  input wire logic rst_b_i,
  aioc_if.dev link,
  input wire logic [7:0] analog_code_i,
  output logic [7:0] primary_output_reg_o,
  output logic [7:0] secondary_output_reg_o,
  output logic sampler_hold_o,
  output logic [7:0] result_o
);
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } aioc_conv_e;

  aioc_conv_e state_r;
  aioc_conv_e state_nxt;
  logic cs_d_r;
  logic wr_d_r;
  logic rd_d_r;
  logic st_d_r;
  logic [7:0] pri_r;
  logic [7:0] sec_r;
  logic [7:0] held_r;
  logic [7:0] sar_r;
  logic [7:0] result_r;
  logic [2:0] bit_r;
  logic [7:0] div_r;
  logic cclk_r;
  logic done_n_r;
  logic read_seen_r;

  // Pin decode; the other end drives on this clock so no synchroniser
  wire cs_low = !link.chip_select_n;
  wire rd_low = !link.read_strobe_n;
  wire read_act = cs_low && rd_low;
  wire wr_rise = link.store_strobe_n && !wr_d_r;
  wire load_ok = wr_rise && !cs_d_r;
  wire pin_rst = !link.reset_n;
  wire trig_fall = !link.convert_trigger_n && st_d_r;
  wire rd_start = read_act && !(!cs_d_r && !rd_d_r) && link.convert_trigger_n;
  wire start = (state_r == ST_IDLE) && (trig_fall || rd_start);
  wire half_tick = (div_r == 8'(aioc_pkg::CONV_HALF_CYC - 1));
  wire bit_tick = half_tick && cclk_r;
  wire last_bit = bit_tick && (bit_r == 3'd0);
  wire [7:0] trial = sar_r | (8'h01 << bit_r);
  wire [7:0] sar_dec = (held_r >= trial) ? trial : sar_r;
  wire rel_rise = read_seen_r && (link.chip_select_n || link.read_strobe_n);

  // Conversion state selection
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (start) state_nxt = ST_CONV;
      end
      ST_CONV:
      begin
        if (last_bit) state_nxt = ST_IDLE;
      end
    endcase
  end

  // Previous pin levels for edge detection
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cs_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
      st_d_r <= 1'b1;
    end
    else
    begin
      cs_d_r <= link.chip_select_n;
      wr_d_r <= link.store_strobe_n;
      rd_d_r <= link.read_strobe_n;
      st_d_r <= link.convert_trigger_n;
    end
  end

  // Output registers; edge-loaded, so a long low strobe changes nothing
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || pin_rst)
    begin
      pri_r <= aioc_pkg::OUT_RESET;
      sec_r <= aioc_pkg::OUT_RESET;
    end
    else if (load_ok)
    begin
      if (!link.channel_pick) pri_r <= link.data_bus;
      else sec_r <= link.data_bus;
    end
  end

  // Conversion clock divider, runs only while converting
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || state_r == ST_IDLE)
    begin
      div_r <= 8'h00;
      cclk_r <= 1'b0;
    end
    else if (half_tick)
    begin
      div_r <= 8'h00;
      cclk_r <= !cclk_r;
    end
    else
    begin
      div_r <= div_r + 8'h01;
    end
  end

  // Successive approximation, one bit per conversion clock fall
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= ST_IDLE;
      held_r <= 8'h00;
      sar_r <= 8'h00;
      bit_r <= 3'd7;
      result_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (start)
      begin
        held_r <= analog_code_i;
        sar_r <= 8'h00;
        bit_r <= 3'(aioc_pkg::CONV_BITS - 1);
      end
      else if (last_bit)
      begin
        result_r <= sar_dec;
        sar_r <= 8'h00;
      end
      else if (bit_tick)
      begin
        sar_r <= sar_dec;
        bit_r <= bit_r - 3'd1;
      end
    end
  end

  // Done flag: end of conversion beats a release or pin reset
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      done_n_r <= 1'b1;
      read_seen_r <= 1'b0;
    end
    else
    begin
      if (last_bit) done_n_r <= 1'b0;
      else if (pin_rst) done_n_r <= 1'b1;
      else if (rel_rise) done_n_r <= 1'b1;
      if (rel_rise || last_bit) read_seen_r <= 1'b0;
      else if (read_act && !done_n_r && state_r == ST_IDLE) read_seen_r <= 1'b1;
    end
  end

  // Pin outputs; old result stays on the bus while converting
  assign link.busy_n = (state_r == ST_IDLE);
  assign link.conv_clk = cclk_r;
  assign link.done_flag_n = done_n_r;
  assign link.dev_data = result_r;
  assign link.dev_data_oe = read_act;
  assign sampler_hold_o = (state_r == ST_CONV);
  assign primary_output_reg_o = pri_r;
  assign secondary_output_reg_o = sec_r;
  assign result_o = result_r;
endmodule : aioc_dev

// >>> dv/aioc_monitor.sv
`timescale 1ns/1ps
module aioc_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic chip_select_n,
  input wire logic store_strobe_n,
  input wire logic read_strobe_n,
  input wire logic channel_pick,
  input wire logic convert_trigger_n,
  input wire logic reset_n,
  input wire logic dev_data_oe,
  input wire logic busy_n,
  input wire logic done_flag_n,
  input wire logic conv_clk
);
  localparam int CONV_LEN = 2 * aioc_pkg::CONV_HALF_CYC * aioc_pkg::CONV_BITS;
  logic [9:0] low_cnt_r;
  logic [9:0] low_cnt_nxt;

  // Counts busy low cycles; too long a count would hide a stuck converter
  assign low_cnt_nxt = busy_n ? 10'h000 : low_cnt_r + 10'h001;
  always_ff @(posedge clock_i)
  begin
    low_cnt_r <= rst_b_i ? low_cnt_nxt : 10'h000;
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // Steps of a write and of the two kinds of start
  sequence s_write_low;
    !chip_select_n && !store_strobe_n;
  endsequence
  sequence s_start_trig;
    busy_n && $fell(convert_trigger_n);
  endsequence
  sequence s_start_rd;
    busy_n && convert_trigger_n && !chip_select_n && !read_strobe_n
      && $past(chip_select_n || read_strobe_n);
  endsequence

  property p_clk_idle;
    busy_n && $past(busy_n) |-> !conv_clk;
  endproperty
  property p_clk_start;
    $fell(busy_n) |-> ##[1:40] conv_clk;
  endproperty
  property p_busy_len;
    $rose(busy_n) |-> low_cnt_r == 10'(CONV_LEN);
  endproperty
  property p_trig_start;
    s_start_trig |=> !busy_n;
  endproperty
  property p_rd_start;
    s_start_rd |=> !busy_n;
  endproperty
  property p_done_end;
    $rose(busy_n) |-> !done_flag_n;
  endproperty
  property p_done_rel;
    busy_n && !done_flag_n && !chip_select_n && $rose(read_strobe_n) |-> ##[0:2] done_flag_n;
  endproperty
  property p_reset_done;
    !reset_n && busy_n |=> done_flag_n;
  endproperty
  property p_oe;
    dev_data_oe == (!chip_select_n && !read_strobe_n);
  endproperty
  property p_pick_stable;
    s_write_low ##1 s_write_low |-> $stable(channel_pick);
  endproperty
  property p_no_retrig;
    $fell(convert_trigger_n) |-> busy_n;
  endproperty

  a_clk_idle: assert property (p_clk_idle)
    else $error("conversion clock runs while idle");
  a_clk_start: assert property (p_clk_start)
    else $error("conversion clock did not start");
  a_busy_len: assert property (p_busy_len)
    else $error("busy low time wrong");
  a_trig_start: assert property (p_trig_start)
    else $error("trigger fall did not start conversion");
  a_rd_start: assert property (p_rd_start)
    else $error("select and read did not start conversion");
  a_done_end: assert property (p_done_end)
    else $error("done flag not set at end");
  a_done_rel: assert property (p_done_rel)
    else $error("done flag not released");
  a_reset_done: assert property (p_reset_done)
    else $error("reset pin did not force done high");
  a_oe: assert property (p_oe)
    else $error("data bus enable wrong");
  a_pick_stable: assert property (p_pick_stable)
    else $error("channel pick moved during write");
  a_no_retrig: assert property (p_no_retrig)
    else $error("trigger pulsed during conversion");
endmodule : aioc_monitor

// >>> dv/analog_io_bus_control_tb_top.sv
`timescale 1ns/1ps
module analog_io_bus_control_tb_top;
  logic clock_i;
  logic rst_b_i;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rdat;
  logic [1:0] htrans;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic hold;
  logic [7:0] analog_code_i;
  logic [7:0] pri;
  logic [7:0] sec;
  logic [7:0] res;
  logic [7:0] codes [2];
  int n_fail;
  int samples_checked;

  aioc_if link ();
  aioc_host aioc_host_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  aioc_dev aioc_dev_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(link),
    .analog_code_i(analog_code_i), .primary_output_reg_o(pri), .secondary_output_reg_o(sec),
    .sampler_hold_o(hold), .result_o(res));
  aioc_monitor aioc_monitor_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .chip_select_n(link.chip_select_n), .store_strobe_n(link.store_strobe_n),
    .read_strobe_n(link.read_strobe_n), .channel_pick(link.channel_pick),
    .convert_trigger_n(link.convert_trigger_n), .reset_n(link.reset_n),
    .dev_data_oe(link.dev_data_oe), .busy_n(link.busy_n), .done_flag_n(link.done_flag_n),
    .conv_clk(link.conv_clk));

  // 250 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB transfer; waits on hready, never on a cycle count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : ahb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdat);
  endtask : rd_chk

  // Polls status until a bit reaches a level, bounded
  task automatic wait_stat(input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      ahb(1'b0, aioc_pkg::STAT_OFS, 32'h0000_0000);
      k++;
    end
    while (rdat[b] !== v && k < 400);
    // A poll that runs out counts as a mismatch, so a hang cannot pass
    if (rdat[b] !== v)
    begin
      n_fail++;
      $display("[ERR] stat bit %0d expected %b seen %b", b, v, rdat[b]);
    end
  endtask : wait_stat

  task automatic cmd(input aioc_pkg::aioc_op_e o, input logic [7:0] d);
    ahb(1'b1, aioc_pkg::CMD_OFS, {16'h0000, d, 5'h00, o});
  endtask : cmd

  task automatic run(input aioc_pkg::aioc_op_e o, input logic [7:0] d);
    cmd(o, d);
    wait_stat(0, 1'b0);
  endtask : run

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // Watchdog, well beyond four conversions plus bus traffic
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    int k;
    rst_b_i = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    analog_code_i = 8'h00;
    codes = '{8'h5A, 8'h21};
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    rd_chk("stat", aioc_pkg::STAT_OFS, 32'h0000_0006);
    rd_chk("cfg", aioc_pkg::CFG_OFS, 32'h0000_0000);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    chk("pri", 32'h0000_0000, {24'h00_0000, pri});
    $display("test reset finished");
    run(aioc_pkg::OP_WR_PRI, 8'hA5);
    run(aioc_pkg::OP_WR_SEC, 8'h3C);
    chk("pri", 32'h0000_00A5, {24'h00_0000, pri});
    chk("sec", 32'h0000_003C, {24'h00_0000, sec});
    run(aioc_pkg::OP_WR_PRI, 8'h5A);
    chk("pri", 32'h0000_005A, {24'h00_0000, pri});
    chk("sec", 32'h0000_003C, {24'h00_0000, sec});
    $display("test writes finished");
    // Strobe-started conversions; old result must show while converting
    for (int i = 0; i < 2; i++)
    begin
      analog_code_i <= codes[i];
      cmd(aioc_pkg::OP_STRB_CONV, 8'h00);
      k = 0;
      while (link.busy_n !== 1'b0 && k < 200)
      begin
        @(posedge clock_i);
        k++;
      end
      @(posedge clock_i);
      chk("old data", (i == 0) ? 32'h0000_0000 : 32'h0000_005A, {24'h00_0000, link.data_bus});
      chk("hold", 32'h0000_0001, {31'h0000_0000, hold});
      wait_stat(0, 1'b0);
      rd_chk("result", aioc_pkg::RESULT_OFS, {24'h00_0000, codes[i]});
      rd_chk("stat", aioc_pkg::STAT_OFS, 32'h0000_0006);
    end
    $display("test strobe finished");
    analog_code_i <= 8'hC3;
    ahb(1'b1, aioc_pkg::CFG_OFS, 32'h0000_0001);
    wait_stat(2, 1'b0);
    chk("res", 32'h0000_00C3, {24'h00_0000, res});
    rd_chk("stat", aioc_pkg::STAT_OFS, 32'h0000_0002);
    run(aioc_pkg::OP_RESET, 8'h00);
    chk("pri", 32'h0000_0000, {24'h00_0000, pri});
    chk("sec", 32'h0000_0000, {24'h00_0000, sec});
    rd_chk("stat", aioc_pkg::STAT_OFS, 32'h0000_0006);
    chk("res", 32'h0000_00C3, {24'h00_0000, res});
    $display("test pin reset finished");
    analog_code_i <= 8'h96;
    run(aioc_pkg::OP_TRIG, 8'h00);
    wait_stat(2, 1'b0);
    run(aioc_pkg::OP_READ, 8'h00);
    rd_chk("result", aioc_pkg::RESULT_OFS, 32'h0000_0096);
    rd_chk("stat", aioc_pkg::STAT_OFS, 32'h0000_0006);
    $display("test trigger finished");
    complete_run();
  end
endmodule : analog_io_bus_control_tb_top
